// *** hw/lpwvm_pkg.sv ***
// Purpose: Shared constants and types for the low-power wake and supply monitor block
// Assumes: 10 MHz fast system clock; AHB-Lite register access with 32-bit words
// Notes: Vector values are the lower address of each vector pair

package lpwvm_pkg;

  // Wake request indices, also the priority order (lower index wins)
  localparam int NUM_WAKE = 10;
  localparam int W_IRQ = 0;
  localparam int W_DEBUG = 1;
  localparam int W_KEYPAD = 2;
  localparam int W_TOVF = 3;
  localparam int W_TCH1 = 4;
  localparam int W_TCH0 = 5;
  localparam int W_ADC = 6;
  localparam int W_PFAULT = 7;
  localparam int W_RELOAD = 8;
  localparam int W_FINE = 9;

  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [NUM_WAKE-1:0][15:0] WAKE_VEC = {
    16'hFFEC, 16'hFFEE, 16'hFFF0, 16'hFFDE, 16'hFFF6,
    16'hFFF4, 16'hFFF2, 16'hFFE0, 16'hFFFC, 16'hFFFA
  };
  // Requests that may also end stop mode
  localparam logic [NUM_WAKE-1:0] STOP_WAKE_MASK = 10'h007;

  // Stop recovery lengths in fast system clock cycles
  localparam int REC_LONG_CYCLES = 4096;
  localparam int REC_SHORT_CYCLES = 32;
  localparam logic [11:0] REC_LONG_LOAD = 12'(REC_LONG_CYCLES - 1);
  localparam logic [11:0] REC_SHORT_LOAD = 12'(REC_SHORT_CYCLES - 1);

  // Register byte offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_VECTOR = 8'h0C;

  // Configuration fields
  localparam int CFG_W = 4;
  localparam int CFG_SHORT_REC_BIT = 0;
  localparam int CFG_STOP_EN_BIT = 1;
  localparam int CFG_RST_DIS_BIT = 2;
  localparam int CFG_PWR_DIS_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;

  // Status fields
  localparam int STAT_LOW_BIT = 0;
  localparam int STAT_TRIP_BIT = 1;
  localparam int STAT_ON_BIT = 2;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} lpwvm_state_e;

endpackage

// *** hw/lpwvm_top.sv ***
// Purpose: Wait/stop exit control, stop recovery gating and supply monitor
// Assumes: Inputs synchronous to SYS_CLK except the two comparator levels
// Notes: Zero-wait AHB-Lite slave, response always OKAY

`timescale 1ns/1ps

module lpwvm_top (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic EXT_RESET_N,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic IRQ_PIN,
  input wire logic DEBUG_HALT_REQ,
  input wire logic KEYPAD_WAKE_REQ,
  input wire logic TIMER_OVF_REQ,
  input wire logic TIMER_CH1_REQ,
  input wire logic TIMER_CH0_REQ,
  input wire logic ADC_REQ,
  input wire logic PWM_FAULT_REQ,
  input wire logic PWM_RELOAD_REQ,
  input wire logic FINE_PWM_REQ,
  input wire logic ENTER_WAIT,
  input wire logic ENTER_STOP,
  input wire logic SUPPLY_BELOW_FALL,
  input wire logic SUPPLY_ABOVE_RISE,
  output logic SYS_RESET,
  output logic [15:0] VECTOR_ADDR,
  output logic VECTOR_LOAD,
  output logic CPU_CLK_EN,
  output logic BUS_CLK_EN,
  output logic OSC_ENABLE,
  output logic PWM_CLK_EN,
  output logic PWM_FORCE_LOW,
  output logic TIMER_CLK_EN,
  output logic SUPPLY_MONITOR_ON
);

  // Highest-priority pending request picks the vector
  function automatic logic [15:0] pick_vector(input logic [lpwvm_pkg::NUM_WAKE-1:0] req);
    logic [15:0] v;
    v = lpwvm_pkg::VEC_RESET;
    for (int i = lpwvm_pkg::NUM_WAKE - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = lpwvm_pkg::WAKE_VEC[i];
      end
    end
    return v;
  endfunction

  lpwvm_pkg::lpwvm_state_e state_reg, state_next;
  logic [lpwvm_pkg::CFG_W-1:0] cfg_reg;
  logic [11:0] rec_cnt_reg;
  logic [15:0] vec_reg;
  logic vec_pending_reg;
  logic load_reg;
  logic irq_prev_reg;
  logic below_meta_reg, below_reg, above_meta_reg, above_reg;
  logic low_flag_reg;
  logic trip_reg;
  logic wr_pend_reg;
  logic rd_en_reg;
  logic [7:0] addr_reg;
  logic [12:0] rec_len_reg;
  logic rec_short_reg;

  logic irq_edge;
  logic [lpwvm_pkg::NUM_WAKE-1:0] wake_req;
  logic [lpwvm_pkg::NUM_WAKE-1:0] stop_req;
  logic reset_src;
  logic monitor_on;
  logic short_sel;
  logic accept;
  logic may_enter;

  assign short_sel = cfg_reg[lpwvm_pkg::CFG_SHORT_REC_BIT];
  assign irq_edge = irq_prev_reg & ~IRQ_PIN;

  assign wake_req[lpwvm_pkg::W_IRQ] = irq_edge;
  assign wake_req[lpwvm_pkg::W_DEBUG] = DEBUG_HALT_REQ;
  assign wake_req[lpwvm_pkg::W_KEYPAD] = KEYPAD_WAKE_REQ;
  assign wake_req[lpwvm_pkg::W_TOVF] = TIMER_OVF_REQ;
  assign wake_req[lpwvm_pkg::W_TCH1] = TIMER_CH1_REQ;
  assign wake_req[lpwvm_pkg::W_TCH0] = TIMER_CH0_REQ;
  assign wake_req[lpwvm_pkg::W_ADC] = ADC_REQ;
  assign wake_req[lpwvm_pkg::W_PFAULT] = PWM_FAULT_REQ;
  assign wake_req[lpwvm_pkg::W_RELOAD] = PWM_RELOAD_REQ;
  assign wake_req[lpwvm_pkg::W_FINE] = FINE_PWM_REQ;
  assign stop_req = wake_req & lpwvm_pkg::STOP_WAKE_MASK;

  // Watchdog has no clock in stop, so it cannot end stop
  assign reset_src = ~EXT_RESET_N | trip_reg | (WATCHDOG_TIMEOUT & (state_reg != lpwvm_pkg::ST_STOP));

  // Monitor power, stop participation
  assign monitor_on = ~cfg_reg[lpwvm_pkg::CFG_PWR_DIS_BIT] &
                      ((state_reg != lpwvm_pkg::ST_STOP) | cfg_reg[lpwvm_pkg::CFG_STOP_EN_BIT]);

  assign may_enter = ~reset_src & ~vec_pending_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      lpwvm_pkg::ST_RUN: begin
        if (may_enter && ENTER_STOP) begin
          state_next = lpwvm_pkg::ST_STOP;
        end else if (may_enter && ENTER_WAIT) begin
          state_next = lpwvm_pkg::ST_WAIT;
        end
      end
      lpwvm_pkg::ST_WAIT: begin
        if (reset_src || (|wake_req)) begin
          state_next = lpwvm_pkg::ST_RUN;
        end
      end
      lpwvm_pkg::ST_STOP: begin
        if (reset_src || (|stop_req)) begin
          state_next = lpwvm_pkg::ST_RECOVER;
        end
      end
      lpwvm_pkg::ST_RECOVER: begin
        if (rec_cnt_reg == 12'h000) begin
          state_next = lpwvm_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= lpwvm_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stop recovery counter
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rec_cnt_reg <= 12'h000;
    end else if (state_reg == lpwvm_pkg::ST_STOP) begin
      rec_cnt_reg <= short_sel ? lpwvm_pkg::REC_SHORT_LOAD : lpwvm_pkg::REC_LONG_LOAD;
    end else if (state_reg == lpwvm_pkg::ST_RECOVER && rec_cnt_reg != 12'h000) begin
      rec_cnt_reg <= rec_cnt_reg - 12'h001;
    end
  end

  // Vector selection and pending load
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      vec_reg <= lpwvm_pkg::VEC_RESET;
      vec_pending_reg <= 1'b1;
      load_reg <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      if (reset_src && state_reg != lpwvm_pkg::ST_RECOVER) begin
        vec_reg <= lpwvm_pkg::VEC_RESET;
        vec_pending_reg <= 1'b1;
      end else if (state_reg == lpwvm_pkg::ST_WAIT && (|wake_req)) begin
        vec_reg <= pick_vector(wake_req);
        vec_pending_reg <= 1'b1;
      end else if (state_reg == lpwvm_pkg::ST_STOP && (|stop_req)) begin
        vec_reg <= pick_vector(stop_req);
        vec_pending_reg <= 1'b1;
      end else if (vec_pending_reg && state_reg == lpwvm_pkg::ST_RUN && !reset_src) begin
        vec_pending_reg <= 1'b0;
        load_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_prev_reg <= 1'b1;
    end else begin
      irq_prev_reg <= IRQ_PIN;
    end
  end

  // Comparator level synchronisers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      below_meta_reg <= 1'b0;
      below_reg <= 1'b0;
      above_meta_reg <= 1'b0;
      above_reg <= 1'b0;
    end else begin
      below_meta_reg <= SUPPLY_BELOW_FALL;
      below_reg <= below_meta_reg;
      above_meta_reg <= SUPPLY_ABOVE_RISE;
      above_reg <= above_meta_reg;
    end
  end

  // Low flag and forced reset hysteresis; no interrupt path exists
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      low_flag_reg <= 1'b0;
      trip_reg <= 1'b0;
    end else begin
      if (monitor_on && below_reg) begin
        low_flag_reg <= 1'b1;
      end else if (monitor_on && above_reg) begin
        low_flag_reg <= 1'b0;
      end
      if (monitor_on && below_reg && !cfg_reg[lpwvm_pkg::CFG_RST_DIS_BIT]) begin
        trip_reg <= 1'b1;
      end else if (above_reg) begin
        trip_reg <= 1'b0;
      end
    end
  end

  // AHB-Lite slave
  assign accept = HSEL & HTRANS[1] & HREADY;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= accept & HWRITE;
      rd_en_reg <= accept & ~HWRITE;
      if (accept) begin
        addr_reg <= HADDR[7:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_reg <= lpwvm_pkg::CFG_RESET;
    end else if (wr_pend_reg && addr_reg == lpwvm_pkg::ADDR_CONFIG) begin
      cfg_reg <= HWDATA[lpwvm_pkg::CFG_W-1:0];
    end
  end

  always_comb begin
    HRDATA = 32'h0000_0000;
    if (rd_en_reg) begin
      unique case (addr_reg)
        lpwvm_pkg::ADDR_CONFIG: HRDATA = {28'h000_0000, cfg_reg};
        lpwvm_pkg::ADDR_STATUS: HRDATA = {29'h0000_0000, monitor_on, trip_reg, low_flag_reg};
        lpwvm_pkg::ADDR_POWER: HRDATA = {18'h0_0000, rec_cnt_reg, state_reg};
        lpwvm_pkg::ADDR_VECTOR: HRDATA = {15'h0000, vec_pending_reg, vec_reg};
        default: HRDATA = 32'h0000_0000;
      endcase
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  assign SYS_RESET = reset_src;
  assign VECTOR_ADDR = vec_reg;
  assign VECTOR_LOAD = load_reg;
  assign CPU_CLK_EN = (state_reg == lpwvm_pkg::ST_RUN);
  assign BUS_CLK_EN = (state_reg == lpwvm_pkg::ST_RUN) | (state_reg == lpwvm_pkg::ST_WAIT);
  assign OSC_ENABLE = (state_reg != lpwvm_pkg::ST_STOP);
  assign PWM_CLK_EN = BUS_CLK_EN;
  assign PWM_FORCE_LOW = (state_reg == lpwvm_pkg::ST_STOP) | (state_reg == lpwvm_pkg::ST_RECOVER);
  assign TIMER_CLK_EN = BUS_CLK_EN;
  assign SUPPLY_MONITOR_ON = monitor_on;

  // Recovery length bookkeeping for checks
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rec_len_reg <= 13'h0000;
      rec_short_reg <= 1'b0;
    end else begin
      rec_len_reg <= (state_reg == lpwvm_pkg::ST_RECOVER) ? rec_len_reg + 13'h0001 : 13'h0000;
      if (state_reg == lpwvm_pkg::ST_STOP) begin
        rec_short_reg <= short_sel;
      end
    end
  end

  AST_RESET_VECTOR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (reset_src && state_reg != lpwvm_pkg::ST_RECOVER)
    |-> SYS_RESET ##1 (vec_reg == 16'hFFFE && vec_pending_reg && !VECTOR_LOAD))
    else $error("Reset did not select the reset vector");
  AST_IRQ_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_WAIT && irq_edge && !reset_src) |=> (vec_reg == 16'hFFFA && CPU_CLK_EN))
    else $error("Request pin edge did not wake with its vector");
  AST_DEBUG_STOP_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_STOP && DEBUG_HALT_REQ && !irq_edge && !reset_src)
    |=> (vec_reg == 16'hFFFC && state_reg == lpwvm_pkg::ST_RECOVER))
    else $error("Debug halt did not end stop with its vector");
  AST_KEYPAD_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_WAIT && wake_req[2:0] == 3'h4 && !reset_src) |=> vec_reg == 16'hFFE0)
    else $error("Keypad wake used the wrong vector");
  AST_TIMER_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_WAIT && wake_req == 10'h008 && !reset_src) |=> vec_reg == 16'hFFF2)
    else $error("Timer overflow wake used the wrong vector");
  AST_ADC_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_WAIT && wake_req == 10'h040 && !reset_src) |=> vec_reg == 16'hFFDE)
    else $error("Converter wake used the wrong vector");
  AST_PWM_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_WAIT && wake_req == 10'h100 && !reset_src) |=> vec_reg == 16'hFFEE)
    else $error("PWM reload wake used the wrong vector");
  AST_FINE_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_WAIT && wake_req == 10'h200 && !reset_src) |=> vec_reg == 16'hFFEC)
    else $error("Fine PWM wake used the wrong vector");
  AST_STOP_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_STOP && stop_req == 10'h000 && !reset_src) |=> state_reg == lpwvm_pkg::ST_STOP)
    else $error("Stop ended without a permitted event");
  AST_REC_LONG: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_RECOVER && state_next == lpwvm_pkg::ST_RUN && !rec_short_reg)
    |-> rec_len_reg == 13'd4095)
    else $error("Full recovery was not 4096 cycles");
  AST_REC_SHORT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_RECOVER && state_next == lpwvm_pkg::ST_RUN && rec_short_reg)
    |-> rec_len_reg == 13'd31)
    else $error("Short recovery was not 32 cycles");
  AST_WAIT_CLOCKS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    state_reg == lpwvm_pkg::ST_WAIT |-> (OSC_ENABLE && BUS_CLK_EN && PWM_CLK_EN && !CPU_CLK_EN))
    else $error("Wait disturbed the derived clocks");
  AST_STOP_CLOCKS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_RUN && state_next == lpwvm_pkg::ST_STOP)
    |=> (!OSC_ENABLE && !BUS_CLK_EN && PWM_FORCE_LOW && !TIMER_CLK_EN))
    else $error("Stop left clocks or PWM outputs active");
  AST_TRIP_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (trip_reg && !above_reg) |=> (trip_reg && SYS_RESET))
    else $error("Supply reset released below rising threshold");
  AST_LOW_FLAG: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (monitor_on && $rose(below_reg)) |=> ##1 low_flag_reg)
    else $error("Low flag not set below falling threshold");
  AST_MONITOR_STOP: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (state_reg == lpwvm_pkg::ST_STOP && !cfg_reg[lpwvm_pkg::CFG_STOP_EN_BIT]) |-> !SUPPLY_MONITOR_ON)
    else $error("Monitor ran in stop without stop enable");

endmodule

// *** test/lpwvm_cpu_model.sv ***
// Purpose: CPU core and wake request sources facing the wake controller
// Assumes: Drives change right after a rising clock edge
// Notes: Counts and records every vector fetch
`timescale 1ns/1ps
module lpwvm_cpu_model (
  input wire logic clk,
  input wire logic vload,
  input wire logic [15:0] vaddr,
  output logic enter_wait,
  output logic enter_stop,
  output logic irq_pin,
  output logic [lpwvm_pkg::NUM_WAKE-1:0] req,
  output logic [15:0] last_vec,
  output int loads
);
  initial begin
    enter_wait = 1'h0;
    enter_stop = 1'h0;
    irq_pin = 1'h1;
    req = '0;
    last_vec = 16'h0000;
    loads = 0;
  end
  always @(posedge clk) begin
    if (vload === 1'h1) begin
      last_vec <= vaddr;
      loads <= loads + 1;
    end
  end
  // One-cycle sleep command issued from RUN
  task automatic sleep(input logic to_stop);
    @(posedge clk);
    enter_stop <= to_stop;
    enter_wait <= !to_stop;
    @(posedge clk);
    enter_stop <= 1'h0;
    enter_wait <= 1'h0;
  endtask
  // Request held until a vector is fetched
  task automatic wake(input int idx, output logic [15:0] vec);
    int start;
    start = loads;
    @(posedge clk);
    if (idx == lpwvm_pkg::W_IRQ) irq_pin <= 1'h0;
    else req[idx] <= 1'h1;
    while (loads == start) @(posedge clk);
    vec = last_vec;
    irq_pin <= 1'h1;
    req <= '0;
  endtask
  task automatic pulse_req(input int idx, input int cycles);
    @(posedge clk);
    req[idx] <= 1'h1;
    repeat (cycles) @(posedge clk);
    req[idx] <= 1'h0;
  endtask
endmodule

// *** test/lpwvm_tb_top.sv ***
// Purpose: Self-checking bench for wake control, stop recovery and supply monitor
// Assumes: Zero-wait bus slave; comparator levels settle within six cycles
// Notes: Crystal clocking is not modelled; the short recovery bit is set in all stop cases but one, which runs the full 4096 cycles
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, (exp), (got)); \
    end \
  end
module lpwvm_tb_top;
  typedef struct {logic stop; int idx; logic [3:0] cfg; logic [15:0] vec;} lpwvm_row_s;
  lpwvm_row_s rows [13] = '{'{1'h0, 0, 4'h0, 16'hFFFA}, '{1'h0, 1, 4'h0, 16'hFFFC},
    '{1'h0, 2, 4'h0, 16'hFFE0}, '{1'h0, 3, 4'h0, 16'hFFF2}, '{1'h0, 4, 4'h0, 16'hFFF4},
    '{1'h0, 5, 4'h0, 16'hFFF6}, '{1'h0, 6, 4'h0, 16'hFFDE}, '{1'h0, 7, 4'h0, 16'hFFF0},
    '{1'h0, 8, 4'h0, 16'hFFEE}, '{1'h0, 9, 4'h0, 16'hFFEC}, '{1'h1, 0, 4'h3, 16'hFFFA},
    '{1'h1, 1, 4'h0, 16'hFFFC}, '{1'h1, 2, 4'h3, 16'hFFE0}};
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic ext_n = 1'h1;
  logic wdog = 1'h0;
  logic below = 1'h0;
  logic above = 1'h0;
  logic [31:0] hrdata;
  logic hready, hresp, sys_reset, vload, cpu_en, bus_en, osc_en, pwm_en, force_low, tim_en, mon_on;
  logic ew, es, irq;
  logic [15:0] vaddr, last_vec;
  logic [lpwvm_pkg::NUM_WAKE-1:0] req;
  logic [6:0] outs;
  int loads;
  int err_total = 0;
  int comparisons = 0;
  assign outs = {cpu_en, bus_en, osc_en, pwm_en, tim_en, force_low, mon_on};
  always #50 clk = ~clk;
  lpwvm_top DUT (.SYS_CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .EXT_RESET_N(ext_n), .WATCHDOG_TIMEOUT(wdog),
    .IRQ_PIN(irq), .DEBUG_HALT_REQ(req[1]), .KEYPAD_WAKE_REQ(req[2]), .TIMER_OVF_REQ(req[3]),
    .TIMER_CH1_REQ(req[4]), .TIMER_CH0_REQ(req[5]), .ADC_REQ(req[6]), .PWM_FAULT_REQ(req[7]),
    .PWM_RELOAD_REQ(req[8]), .FINE_PWM_REQ(req[9]), .ENTER_WAIT(ew), .ENTER_STOP(es),
    .SUPPLY_BELOW_FALL(below), .SUPPLY_ABOVE_RISE(above), .SYS_RESET(sys_reset),
    .VECTOR_ADDR(vaddr), .VECTOR_LOAD(vload), .CPU_CLK_EN(cpu_en), .BUS_CLK_EN(bus_en),
    .OSC_ENABLE(osc_en), .PWM_CLK_EN(pwm_en), .PWM_FORCE_LOW(force_low),
    .TIMER_CLK_EN(tim_en), .SUPPLY_MONITOR_ON(mon_on));
  lpwvm_cpu_model cpu (.clk(clk), .vload(vload), .vaddr(vaddr), .enter_wait(ew), .enter_stop(es),
    .irq_pin(irq), .req(req), .last_vec(last_vec), .loads(loads));
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
    hsel <= 1'h0;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
  initial begin
    logic [31:0] rd;
    logic [15:0] vec;
    int rec;
    int n;
    cycles(6);
    resetn <= 1'h1;
    cycles(3);
    `CHK("reset vector", 16'hFFFE, last_vec)
    ahb(1'h0, 8'h00, 32'h0, rd);
    `CHK("config", 32'h0, rd)
    ahb(1'h1, 8'h04, 32'hFFFFFFFF, rd);
    ahb(1'h0, 8'h04, 32'h0, rd);
    `CHK("status", 32'h4, rd)
    `CHK("okay response", 1'h0, hresp)
    ahb(1'h1, 8'h10, 32'hFFFFFFFF, rd);
    ahb(1'h0, 8'h10, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'h1, 8'h00, 32'h8, rd);
    @(negedge clk);
    `CHK("monitor off", 1'h0, mon_on)
    foreach (rows[i]) begin
      ahb(1'h1, 8'h00, {28'h0, rows[i].cfg}, rd);
      cpu.sleep(rows[i].stop);
      @(negedge clk);
      if (rows[i].stop) begin
        `CHK("stop outputs", {6'h01, rows[i].cfg[1]}, outs)
        cpu.pulse_req(lpwvm_pkg::W_TOVF, 8);
        @(negedge clk);
        `CHK("stop held", 1'h0, osc_en)
      end else begin
        `CHK("wait outputs", 7'h3D, outs)
      end
      rec = 0;
      fork
        cpu.wake(rows[i].idx, vec);
        while (cpu_en !== 1'h1) begin
          @(negedge clk);
          if (bus_en === 1'h0 && osc_en === 1'h1) rec++;
        end
      join
      `CHK("vector", rows[i].vec, vec)
      `CHK("recovery", rows[i].stop ? (rows[i].cfg[0] ? 32 : 4096) : 0, rec)
      @(negedge clk);
      `CHK("run outputs", 7'h7D, outs)
    end
    ahb(1'h1, 8'h00, 32'h4, rd);
    below <= 1'h1;
    cycles(6);
    `CHK("polled reset", 1'h0, sys_reset)
    ahb(1'h0, 8'h04, 32'h0, rd);
    `CHK("flag low supply", 32'h5, rd)
    below <= 1'h0;
    cycles(6);
    ahb(1'h0, 8'h04, 32'h0, rd);
    `CHK("flag between", 32'h5, rd)
    above <= 1'h1;
    cycles(6);
    ahb(1'h0, 8'h04, 32'h0, rd);
    `CHK("flag above", 32'h4, rd)
    above <= 1'h0;
    below <= 1'h1;
    cycles(6);
    below <= 1'h0;
    resetn <= 1'h0;
    cycles(2);
    resetn <= 1'h1;
    cycles(3);
    ahb(1'h0, 8'h04, 32'h0, rd);
    `CHK("flag reset", 32'h4, rd)
    n = loads;
    below <= 1'h1;
    cycles(6);
    `CHK("supply reset", 1'h1, sys_reset)
    below <= 1'h0;
    cycles(6);
    `CHK("reset held", 1'h1, sys_reset)
    above <= 1'h1;
    cycles(6);
    `CHK("reset ends", 1'h0, sys_reset)
    above <= 1'h0;
    cycles(4);
    `CHK("supply vector", n + 1, loads)
    for (int s = 0; s < 2; s++) begin
      n = loads;
      ext_n <= (s != 0);
      wdog <= (s == 1);
      @(negedge clk);
      `CHK("reset source", 1'h1, sys_reset)
      @(posedge clk);
      ext_n <= 1'h1;
      wdog <= 1'h0;
      cycles(4);
      `CHK("reset loads", n + 1, loads)
      `CHK("reset vec", 16'hFFFE, last_vec)
    end
    ahb(1'h1, 8'h00, 32'h1, rd);
    cpu.sleep(1'h1);
    wdog <= 1'h1;
    cycles(2);
    wdog <= 1'h0;
    @(negedge clk);
    `CHK("watchdog in stop", 2'h0, {sys_reset, osc_en})
    cpu.wake(lpwvm_pkg::W_KEYPAD, vec);
    `CHK("keypad after watchdog", 16'hFFE0, vec)
    ahb(1'h0, 8'h08, 32'h0, rd);
    `CHK("power word", 32'h0, rd)
    ahb(1'h0, 8'h0C, 32'h0, rd);
    `CHK("vector word", 32'h0000FFE0, rd)
    stop_test();
  end
endmodule
